// ---- logic/csu_map.vh ----
// Purpose: Register map, field positions and reset values of the clocked serial unit
// Assumes: Word-addressed Avalon-MM slave, one register per 32-bit word
// Notes:   Register index equals word address; byte address is four times it
`ifndef CSU_MAP_VH
`define CSU_MAP_VH

`define CSU_ADDR_W       28
`define CSU_IDX_MAIN     28'hFFF_FD00
`define CSU_IDX_CLKPH    28'hFFF_FD01
`define CSU_IDX_LEN      28'hFFF_FD02
`define CSU_IDX_STAT     28'hFFF_FD03
`define CSU_IDX_TXBUF    28'hFFF_FD04
`define CSU_IDX_RXBUF    28'hFFF_FD06

`define CSU_RST_MAIN     8'h00
`define CSU_RST_CLKPH    8'h00
`define CSU_RST_LEN      8'h00
`define CSU_RST_STAT     8'h00
`define CSU_RST_BUF      16'h0000

`define CSU_B_PWR        7
`define CSU_B_TXE        6
`define CSU_B_RXE        5
`define CSU_B_DIR        4
`define CSU_B_TMS        1
`define CSU_B_SCE        0
`define CSU_MAIN_WMASK   8'hF3
`define CSU_B_LEN_TOP    3
`define CSU_LEN_BASE     5'h08
`define CSU_LEN_FULL     5'h10
`define CSU_B_TSF        7
`define CSU_B_OVF        0
`define CSU_CKS_EXT      3'h7

`endif

// ---- logic/csu_sync.v ----
// Purpose: Two-flop synchroniser with edge detection on the synchronised level
// Assumes: Input is asynchronous to ref_clk
// Notes:   Edge outputs are one-cycle pulses taken after the second flop
`timescale 1ns/1ps
module csu_sync
(
  // Clock and control
  input  wire ref_clk,
  input  wire srst,
  input  wire ce,
  // Pin side
  input  wire pin_in,
  // Synchronised side
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end
    else if (ce)
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = ce & sync_reg & ~prev_reg;
  assign fall  = ce & ~sync_reg & prev_reg;
endmodule // csu_sync

// ---- logic/csu_clkdiv.v ----
// Purpose: Half-period tick generator for the master serial clock
// Assumes: sel 0..6 gives a half period of 2**sel ref_clk cycles
// Notes:   Counter restarts whenever run is low so the first half is full length
`timescale 1ns/1ps
module csu_clkdiv
(
  // Clock and control
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       ce,
  input  wire       run,
  input  wire [2:0] sel,
  // Tick out
  output wire       tick
);
  reg  [5:0] cnt_reg;
  wire [5:0] limit;

  assign limit = (6'h01 << sel) - 6'h01;
  assign tick  = ce & run & (cnt_reg == limit);

  always @(posedge ref_clk)
  begin
    if (srst)
      cnt_reg <= 6'h00;
    else if (ce)
    begin
      if (!run || tick)
        cnt_reg <= 6'h00;
      else
        cnt_reg <= cnt_reg + 6'h01;
    end
  end
endmodule // csu_clkdiv

// ---- logic/csu_core.v ----
// Purpose: Clocked serial unit: word length, status flags and transfer sequencing
// Assumes: Avalon-MM word addressing; serial pins asynchronous to ref_clk
// Notes:   Fixed timing: output changes on falling clock edge, input sampled on rising
`timescale 1ns/1ps
`include "csu_map.vh"

module csu_core
(
  // Clock and control
  input  wire                   ref_clk,
  input  wire                   srst,
  input  wire                   ce,
  // Avalon-MM slave
  input  wire [`CSU_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  output reg  [31:0]            avs_readdata,
  output wire                   avs_waitrequest,
  // Serial link
  input  wire                   sck_in,
  output wire                   sck_out,
  output wire                   sck_oe,
  input  wire                   si_in,
  output wire                   serial_data_out,
  // Events
  output reg                    receive_complete_irq,
  output reg                    transmit_enable_irq
);
  localparam ST_IDLE  = 1'b0;
  localparam ST_SHIFT = 1'b1;
  // Reset words as parameters so single fields can be selected
  localparam [7:0] RST_LEN  = `CSU_RST_LEN;
  localparam [7:0] RST_STAT = `CSU_RST_STAT;

  reg  [7:0]  main_reg;
  reg  [7:0]  clkph_reg;
  reg  [3:0]  len_reg;
  reg         state_reg;
  reg         ovf_reg;
  reg  [15:0] tx_buf_reg;
  reg         tx_full_reg;
  reg  [15:0] rx_buf_reg;
  reg         rx_unread_reg;
  reg  [15:0] sh_reg;
  reg  [4:0]  bit_cnt_reg;
  reg         sck_lvl_reg;
  reg         so_reg;
  reg         ack_reg;

  wire        pwr;
  wire        txe;
  wire        rxe;
  wire        dir;
  wire        tms;
  wire        sce;
  wire        master;
  wire [4:0]  len;
  wire        busy;
  wire        req;
  wire        do_wr;
  wire        do_rd;
  wire        tick;
  wire        ext_rise;
  wire        ext_fall;
  wire        si_sync;
  wire        rise;
  wire        fall;
  wire        word_end;
  wire [15:0] sh_in;
  wire        start_tx;
  wire        start_rx;
  wire        cont_tx;
  wire        cont_rx;

  function [4:0] word_len;
    input [3:0] cl;
    begin
      if (cl[`CSU_B_LEN_TOP])
        word_len = `CSU_LEN_FULL;
      else
        word_len = `CSU_LEN_BASE + {2'b00, cl[2:0]};
    end
  endfunction

  function [15:0] len_mask;
    input [4:0] n;
    reg   [16:0] ones;
    begin
      ones     = (17'h0_0001 << n) - 17'h0_0001;
      len_mask = ones[15:0];
    end
  endfunction

  function out_bit;
    input [15:0] sh;
    input        lsb_first;
    input [4:0]  n;
    reg   [4:0]  top;
    begin
      top = n - 5'h01;
      if (lsb_first)
        out_bit = sh[0];
      else
        out_bit = sh[top[3:0]];
    end
  endfunction

  function [15:0] shift_in;
    input [15:0] sh;
    input        bit_in;
    input        lsb_first;
    input [4:0]  n;
    reg   [15:0] tmp;
    reg   [4:0]  top;
    begin
      top = n - 5'h01;
      if (lsb_first)
      begin
        tmp              = {1'b0, sh[15:1]};
        tmp[top[3:0]]    = bit_in;
      end
      else
        tmp = {sh[14:0], bit_in};
      shift_in = tmp & len_mask(n);
    end
  endfunction

  assign pwr    = main_reg[`CSU_B_PWR];
  assign txe    = main_reg[`CSU_B_TXE];
  assign rxe    = main_reg[`CSU_B_RXE];
  assign dir    = main_reg[`CSU_B_DIR];
  assign tms    = main_reg[`CSU_B_TMS];
  assign sce    = main_reg[`CSU_B_SCE];
  assign master = (clkph_reg[2:0] != `CSU_CKS_EXT);
  assign len    = word_len(len_reg);
  assign busy   = (state_reg == ST_SHIFT);

  // One wait state: readdata is registered at the edge that drops waitrequest
  assign req             = ce & (avs_read | avs_write);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign do_wr           = req & avs_write & ack_reg;
  assign do_rd           = req & avs_read & ack_reg;

  csu_clkdiv u_div
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .run     (busy & master),
    .sel     (clkph_reg[2:0]),
    .tick    (tick)
  );

  csu_sync u_sck
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .pin_in  (sck_in),
    .level   (),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  csu_sync u_si
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .pin_in  (si_in),
    .level   (si_sync),
    .rise    (),
    .fall    ()
  );

  assign rise     = busy & (master ? (tick & ~sck_lvl_reg) : ext_rise);
  assign fall     = busy & (master ? (tick & sck_lvl_reg) : ext_fall);
  assign word_end = rise & (bit_cnt_reg == len - 5'h01);
  assign sh_in    = shift_in(sh_reg, si_sync, dir, len);

  assign start_tx = do_wr & (avs_address == `CSU_IDX_TXBUF) & pwr & txe & sce;
  assign start_rx = do_rd & (avs_address == `CSU_IDX_RXBUF) & pwr & rxe & ~txe
                    & sce;
  assign cont_tx  = tms & txe & sce & (tx_full_reg | start_tx);
  assign cont_rx  = tms & rxe & ~txe & sce;

  assign sck_out         = sck_lvl_reg;
  assign sck_oe          = pwr & master;
  assign serial_data_out = so_reg;

  // Bus handshake and read data
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg)
      begin
        if (avs_address == `CSU_IDX_MAIN)
          avs_readdata <= {24'h00_0000, main_reg};
        else if (avs_address == `CSU_IDX_CLKPH)
          avs_readdata <= {24'h00_0000, clkph_reg};
        else if (avs_address == `CSU_IDX_LEN)
          avs_readdata <= {28'h000_0000, len_reg};
        else if (avs_address == `CSU_IDX_STAT)
          avs_readdata <= {24'h00_0000, busy, 6'h00, ovf_reg};
        else if (avs_address == `CSU_IDX_TXBUF)
          avs_readdata <= {16'h0000, tx_buf_reg};
        else if (avs_address == `CSU_IDX_RXBUF)
          avs_readdata <= {16'h0000, rx_buf_reg};
        else
          avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Control registers; mode bits only change while powered down
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      main_reg  <= `CSU_RST_MAIN;
      clkph_reg <= `CSU_RST_CLKPH;
      len_reg   <= RST_LEN[3:0];
    end
    else if (do_wr)
    begin
      if (avs_address == `CSU_IDX_MAIN)
      begin
        if (!pwr)
          main_reg <= avs_writedata[7:0] & `CSU_MAIN_WMASK;
        else
        begin
          main_reg[`CSU_B_PWR] <= avs_writedata[`CSU_B_PWR];
          main_reg[`CSU_B_SCE] <= avs_writedata[`CSU_B_SCE];
        end
      end
      else if (avs_address == `CSU_IDX_CLKPH)
      begin
        if (!pwr)
          clkph_reg <= {5'h00, avs_writedata[2:0]};
      end
      else if (avs_address == `CSU_IDX_LEN)
        len_reg <= avs_writedata[3:0];
    end
  end

  // Buffers and overrun bookkeeping
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      tx_buf_reg    <= `CSU_RST_BUF;
      rx_buf_reg    <= `CSU_RST_BUF;
      rx_unread_reg <= 1'b0;
      ovf_reg       <= RST_STAT[`CSU_B_OVF];
    end
    else if (ce)
    begin
      if (do_wr && avs_address == `CSU_IDX_TXBUF)
        tx_buf_reg <= avs_writedata[15:0];
      if (!pwr)
      begin
        ovf_reg       <= 1'b0;
        rx_unread_reg <= 1'b0;
      end
      else
      begin
        if (do_wr && avs_address == `CSU_IDX_STAT)
          ovf_reg <= ovf_reg & avs_writedata[`CSU_B_OVF];
        if (do_rd && avs_address == `CSU_IDX_RXBUF)
          rx_unread_reg <= 1'b0;
        // Completion beats a same-cycle read or clear
        if (word_end)
        begin
          if (rx_unread_reg && !(do_rd && avs_address == `CSU_IDX_RXBUF))
            ovf_reg <= 1'b1;
          if (rxe)
          begin
            rx_buf_reg    <= sh_in;
            rx_unread_reg <= 1'b1;
          end
          else if (!tms)
            rx_unread_reg <= 1'b1;
        end
      end
    end
  end

  // Shift sequencing
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg            <= ST_IDLE;
      tx_full_reg          <= 1'b0;
      sh_reg               <= 16'h0000;
      bit_cnt_reg          <= 5'h00;
      sck_lvl_reg          <= 1'b1;
      so_reg               <= 1'b0;
      receive_complete_irq <= 1'b0;
      transmit_enable_irq  <= 1'b0;
    end
    else if (ce)
    begin
      receive_complete_irq <= 1'b0;
      transmit_enable_irq  <= 1'b0;
      // Power off aborts the word and stops the clock
      if (!pwr)
      begin
        state_reg   <= ST_IDLE;
        tx_full_reg <= 1'b0;
        bit_cnt_reg <= 5'h00;
        sck_lvl_reg <= 1'b1;
      end
      else if (!busy)
      begin
        sck_lvl_reg <= 1'b1;
        if (start_tx)
        begin
          state_reg           <= ST_SHIFT;
          sh_reg              <= avs_writedata[15:0] & len_mask(len);
          so_reg              <= out_bit(avs_writedata[15:0], dir, len);
          bit_cnt_reg         <= 5'h00;
          transmit_enable_irq <= tms;
        end
        else if (start_rx)
        begin
          state_reg   <= ST_SHIFT;
          sh_reg      <= 16'h0000;
          bit_cnt_reg <= 5'h00;
        end
      end
      else
      begin
        if (start_tx && tms)
          tx_full_reg <= 1'b1;
        if (master && tick)
          sck_lvl_reg <= ~sck_lvl_reg;
        // First fall of a word re-presents bit one; a chained word needs it there
        if (fall)
          so_reg <= out_bit(sh_reg, dir, len);
        if (word_end)
        begin
          bit_cnt_reg          <= 5'h00;
          receive_complete_irq <= rxe | ~tms;
          if (cont_tx)
          begin
            // Next word taken from the buffer without a gap
            sh_reg              <= (tx_full_reg ? tx_buf_reg : avs_writedata[15:0])
                                   & len_mask(len);
            tx_full_reg         <= 1'b0;
            transmit_enable_irq <= 1'b1;
          end
          else if (cont_rx)
            sh_reg <= 16'h0000;
          else
          begin
            sh_reg    <= sh_in;
            state_reg <= ST_IDLE;
          end
        end
        else if (rise)
        begin
          sh_reg      <= sh_in;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
      if (!txe)
        so_reg <= 1'b0;
    end
  end
endmodule // csu_core

// ---- sim/csu_peer_model.sv ----
// Purpose: Serial peer that returns a fixed pattern and captures what it hears
// Assumes: Master mode, serial clock idles high between frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module csu_peer_model #(parameter [15:0] PAT = 16'hC3A5)
(
  // Clock
  input  wire        ref_clk,
  // Link
  input  wire        sck,
  input  wire        sdo,
  output reg         si,
  output reg  [15:0] got
);
  reg       sck_q = 1'b1;
  reg [3:0] k     = 4'h0;
  reg [2:0] idle  = 3'h0;
  initial si = 1'b0;
  initial got = 16'h0000;
  always @(posedge ref_clk)
  begin
    sck_q <= sck;
    idle  <= sck ? ((idle == 3'h7) ? idle : idle + 3'h1) : 3'h0;
    if (sck_q && !sck)
    begin
      si <= PAT[4'hF - k];
      k  <= k + 4'h1;
    end
    if (!sck_q && sck)
      got <= {got[14:0], sdo};
    // Idle gap longer than a high phase ends the frame
    if (idle == 3'h6)
    begin
      k  <= 4'h0;
      si <= ~si;
    end
  end
endmodule // csu_peer_model

// ---- sim/csu_core_properties.sv ----
// Purpose: Port-level properties of the clocked serial unit core
// Assumes: Master clock select, one clock domain
// Notes:   Shadows of power, transmit enable, continuous mode and clock select follow taken bus writes
`timescale 1ns/1ps
`include "csu_map.vh"
module csu_core_properties
(
  // Clock and control
  input wire        ref_clk,
  input wire        srst,
  input wire        ce,
  // Register bus
  input wire [27:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Link and events
  input wire        sck_in,
  input wire        sck_out,
  input wire        sck_oe,
  input wire        si_in,
  input wire        serial_data_out,
  input wire        receive_complete_irq,
  input wire        transmit_enable_irq
);
  reg       pwr_sh;
  reg       txe_sh;
  reg       cont_sh;
  reg [2:0] cks_sh;
  reg       sck_q;
  reg [2:0] since_rise;
  wire      take_w = avs_write && !avs_waitrequest;
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      pwr_sh     <= 1'b0;
      txe_sh     <= 1'b0;
      cont_sh    <= 1'b0;
      cks_sh     <= 3'h0;
      sck_q      <= 1'b1;
      since_rise <= 3'h7;
    end
    else if (ce)
    begin
      sck_q      <= sck_out;
      since_rise <= (sck_out && !sck_q) ? 3'h0 : since_rise + {2'h0, since_rise != 3'h7};
      // Mode bits only land while power is off
      if (take_w && avs_address == `CSU_IDX_MAIN)
      begin
        pwr_sh  <= avs_writedata[7];
        txe_sh  <= pwr_sh ? txe_sh : avs_writedata[6];
        cont_sh <= pwr_sh ? cont_sh : avs_writedata[1];
      end
      if (take_w && avs_address == `CSU_IDX_CLKPH && !pwr_sh)
        cks_sh <= avs_writedata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_wait_one: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> s_one_wait) else $error("wait state count wrong");
  a_rd_stands: assert property (!$past(avs_read || avs_write) |-> $stable(avs_readdata))
    else $error("read data moved");
  a_sdo_idle: assert property (!txe_sh ##1 !txe_sh |-> !serial_data_out)
    else $error("data out high with transmit off");
  a_sck_idle: assert property (!pwr_sh ##1 !pwr_sh |-> sck_out)
    else $error("clock not idle with power off");
  a_oe_map: assert property (sck_oe == (pwr_sh && cks_sh != 3'h7))
    else $error("clock enable wrong");
  a_rirq_pulse: assert property (receive_complete_irq |=> !receive_complete_irq)
    else $error("receive event longer than a cycle");
  a_rirq_cause: assert property (receive_complete_irq |->
    since_rise < 3'h3 || (sck_out && !sck_q)) else $error("receive event without clock edge");
  a_tirq_single: assert property (!cont_sh |-> !transmit_enable_irq)
    else $error("transmit event in single mode");
endmodule // csu_core_properties

bind csu_core csu_core_properties csu_core_properties_inst
(
  .ref_clk(ref_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_in(sck_in),
  .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si_in), .serial_data_out(serial_data_out),
  .receive_complete_irq(receive_complete_irq), .transmit_enable_irq(transmit_enable_irq)
);

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the clocked serial unit core
// Assumes: Master clock at four cycles a half period, peer model on the link
// Notes:   Rows cover length codes; hand tests cover flags and modes
`timescale 1ns/1ps
`include "csu_map.vh"
module tb_top;
  localparam [15:0] PAT = 16'hC3A5;
  localparam [27:0] MN  = `CSU_IDX_MAIN;
  localparam [27:0] LN  = `CSU_IDX_LEN;
  localparam [27:0] ST  = `CSU_IDX_STAT;
  localparam [27:0] TX  = `CSU_IDX_TXBUF;
  localparam [27:0] RX  = `CSU_IDX_RXBUF;
  reg         ref_clk       = 1'b0;
  reg         srst          = 1'b1;
  reg         ce            = 1'b1;
  reg  [27:0] avs_address   = 28'h000_0000;
  reg         avs_read      = 1'b0;
  reg         avs_write     = 1'b0;
  reg  [31:0] avs_writedata = 32'h0000_0000;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        sck_out;
  wire        sck_oe;
  wire        si_in;
  wire        serial_data_out;
  wire        receive_complete_irq;
  wire        transmit_enable_irq;
  wire [15:0] got;
  integer     err_count  = 0;
  integer     num_checks = 0;
  integer     i;
  reg  [31:0] rdat;
  reg  [31:0] r;
  reg  [4:0]  len;
  reg  [31:0] row [0:4];
  csu_core csu_core_inst
  (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_in(sck_out),
    .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si_in), .serial_data_out(serial_data_out),
    .receive_complete_irq(receive_complete_irq), .transmit_enable_irq(transmit_enable_irq)
  );
  csu_peer_model #(.PAT(PAT)) csu_peer_model_inst
  (
    .ref_clk(ref_clk), .sck(sck_out), .sdo(serial_data_out), .si(si_in), .got(got)
  );
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Holds the request until waitrequest is seen low
  task bus(input rq, input [27:0] a, input [31:0] wd);
    begin
      @(posedge ref_clk);
      avs_read      <= rq;
      avs_write     <= !rq;
      avs_address   <= a;
      avs_writedata <= wd;
      @(posedge ref_clk);
      while (avs_waitrequest)
        @(posedge ref_clk);
      rdat = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task wr(input [27:0] a, input [31:0] d);
    bus(1'b0, a, d);
  endtask
  task rd(input [27:0] a);
    bus(1'b1, a, 32'h0000_0000);
  endtask
  task wirq(input t);
    integer n;
    begin
      n = 0;
      @(negedge ref_clk);
      while (!(t ? transmit_enable_irq : receive_complete_irq) && n < 400)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk(n < 400, 1, "irq");
      // Peer captures the last bit one cycle after the event
      @(negedge ref_clk);
    end
  endtask
  function [15:0] ord(input [15:0] x, input [4:0] l, input d);
    integer j;
    begin
      ord = 16'h0000;
      for (j = 0; j < l; j = j + 1)
        ord[j] = d ? x[l - 1 - j] : x[j];
    end
  endfunction
  task rstchk;
    begin
      rd(LN);
      chk(rdat, 0, "len");
      rd(ST);
      chk(rdat, 0, "stat");
      rd(28'h000_0123);
      chk(rdat, 0, "unmap");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    #600000;
    err_count = err_count + 1;
    end_of_test;
  end
  initial
  begin
    // Length code, expected length, bit order, transmit word
    row[0] = {4'h0, 5'h08, 6'h00, 1'b0, 16'hA55A};
    row[1] = {4'h7, 5'h0F, 6'h00, 1'b1, 16'h1234};
    row[2] = {4'h8, 5'h10, 6'h00, 1'b0, 16'h8001};
    row[3] = {4'hF, 5'h10, 6'h00, 1'b1, 16'h4C3D};
    row[4] = {4'h3, 5'h0B, 6'h00, 1'b1, 16'hF6E1};
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rstchk;
    for (i = 0; i < 5; i = i + 1)
    begin
      r = row[i];
      len = r[27:23];
      wr(MN, 0);
      wr(`CSU_IDX_CLKPH, 2);
      wr(LN, r[31:28]);
      rd(LN);
      chk(rdat, r[31:28], "len");
      wr(MN, {24'h00_0000, 3'h7, r[16], 4'h1});
      wr(TX, r[15:0]);
      rd(ST);
      chk(rdat, 32'h0000_0080, "busy");
      wirq(0);
      rd(ST);
      chk(rdat, 0, "done");
      chk(ord(got, len, 1'b0), ord(r[15:0], len, r[16]), "txword");
      rd(RX);
      chk(rdat, ord(PAT >> (16 - len), len, r[16]), "rxword");
      $display("row %0d done", i);
    end
    // Transmit-only single mode, overrun and flag writes
    wr(MN, 0);
    wr(LN, 0);
    wr(MN, 32'h0000_00C1);
    rd(RX);
    r = rdat;
    rd(ST);
    chk(rdat, 0, "rxnostart");
    wr(TX, 32'h0000_0011);
    wirq(0);
    rd(RX);
    chk(rdat, r, "rxkeep");
    wr(TX, 32'h0000_0022);
    wirq(0);
    wr(TX, 32'h0000_0033);
    wirq(0);
    rd(ST);
    chk(rdat, 1, "ovf");
    wr(ST, 32'h0000_00FF);
    rd(ST);
    chk(rdat, 1, "ovfw1");
    wr(ST, 0);
    rd(ST);
    chk(rdat, 0, "ovfw0");
    wr(TX, 32'h0000_0044);
    wirq(0);
    rd(ST);
    chk(rdat, 1, "ovf2");
    wr(MN, 0);
    rd(ST);
    chk(rdat, 0, "pwroff");
    $display("overrun test done");
    // Receive-only single mode
    wr(MN, 32'h0000_00A1);
    rd(RX);
    rd(ST);
    chk(rdat, 32'h0000_0080, "rxstart");
    wirq(0);
    rd(RX);
    chk(rdat, 32'h0000_00C3, "rx1");
    wirq(0);
    wr(MN, 32'h0000_00A0);
    rd(RX);
    chk(rdat, 32'h0000_00C3, "rx2");
    rd(ST);
    chk(rdat, 0, "rxstop");
    $display("receive test done");
    // Continuous receive-only, 8 bits, stopped during the second word
    wr(MN, 0);
    wr(LN, 0);
    wr(MN, 32'h0000_00A3);
    rd(RX);
    wirq(0);
    rd(RX);
    chk(rdat, 32'h0000_00C3, "crxw1");
    wr(MN, 32'h0000_0080);
    wirq(0);
    rd(RX);
    chk(rdat, 32'h0000_00A5, "crxw2");
    rd(ST);
    chk(rdat, 0, "crxstop");
    $display("continuous receive test done");
    // Continuous transmit and receive, 16 bits
    wr(MN, 0);
    wr(LN, 8);
    wr(MN, 32'h0000_00E3);
    wr(TX, 32'h0000_1357);
    wirq(1);
    wr(TX, 32'h0000_2468);
    wirq(0);
    chk(got, 32'h0000_1357, "cont1");
    rd(RX);
    chk(rdat, PAT, "crx1");
    wirq(0);
    chk(got, 32'h0000_2468, "cont2");
    rd(RX);
    chk(rdat, PAT, "crx2");
    rd(ST);
    chk(rdat, 0, "cstat");
    $display("continuous test done");
    // Reset in mid transfer
    wr(TX, 32'h0000_5555);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rstchk;
    $display("reset test done");
    end_of_test;
  end
endmodule // tb_top
